//--- rtl/fsk_baseband_ctrl.sv
// control logic of the fsk transceiver: registers, clocks, sync, fee
//
// Contract
// - filter clock divides crystal by twice the 6-bit filter divider value
// - filter clock is twenty times cut-off: cut-off is fxco/(40*div)
// - filter bypass bit routes receive path around the filter
// - demodulator gives up pulse per one, down pulse per zero
// - low control bits: off, count up, count down, up minus down
// - high control bits pick 8, 16, 32 or 64 symbols
// - eight-bit error result is readable by the host
// - result is two's complement; in up mode negative only by wrapping
// - error counter wraps modulo 256 past its signed range
// - sync mode receive runs synchronizer, clock out at bit rate
// - receive bit changes at rising edge; host samples falling
// - sync clock is fxco/(K*2^(7-scale)), meant as sixteen times rate
// - reference divider is six bits, 1 to 63, low bits of reg 7
// - sync scale is three bits in D3..D1 of reg 6
// - one reference divider feeds modulator, bit rate, sync clocks
// - synchronizer locks within 22 bits from worst phase
// - power code zero turns amplifier off, nonzero on, seven max
// - amplifier bypass keeps power level control active
// - transmit zero uses zero-tone dividers, one uses one-tone
// - data pin is input in transmit, output in receive
// - sync transmit samples data on rising bit clock edge
// - bit rate scale 0..6 gives fxco/(K*2^(7-scale))
`timescale 1ns/1ps
`include "fsk_defines.svh"
module fsk_baseband_ctrl #(
  parameter int TX_FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // three-wire programming port
  input  wire logic       prog_en_i,
  input  wire logic       prog_clk_i,
  input  wire logic       prog_data_i,
  output logic            prog_data_o,
  output logic            prog_data_oe_n_o,
  // host data port
  output logic            bit_clock_pin_o,
  input  wire logic       serial_data_pin_i,
  output logic            serial_data_pin_o,
  output logic            serial_data_pin_oe_n_o,
  // demodulator side
  input  wire logic       demod_data_i,
  input  wire logic       demod_up_i,
  input  wire logic       demod_dn_i,
  // analog and synthesizer controls
  output logic            filter_clock_o,
  output logic            channel_filter_bypass_o,
  output logic [2:0]      output_power_level_o,
  output logic            amplifier_enable_o,
  output logic            amplifier_bypass_o,
  output logic            one_tone_dividers_o,
  input  wire logic       tone_ready_i,
  output logic [1:0]      mode_o
);
  fsk_pkg::fsk_state_type st_reg;
  fsk_pkg::fsk_state_type st_next;
  fsk_pkg::fsk_mode_type  mode;
  logic       rx;
  logic       tx;
  logic       sync_en;
  logic [2:0] rsync_s;
  logic [2:0] txrate_s;
  logic [5:0] ref_k;
  logic [5:0] sc_div;
  logic       ref_tick;
  logic       bs_tick;
  logic       tx_tick;
  logic       pg_rise;
  logic       pg_fall;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [0:0] fifo_out_data;
  logic       fifo_push;
  logic       tx_sample;
  logic       up_q;
  logic       dn_q;

  // ------------
  // helper functions
  // ------------
  // true when the low n bits of the prescaler are all ones
  function automatic logic pre_hit(input logic [6:0] cnt,
                                   input logic [2:0] n);
    logic [6:0] mask;
    mask = 7'h7F >> (3'h7 - n);
    mask = (n == 3'h0) ? 7'h00 : mask;
    return (cnt & mask) == mask;
  endfunction

  // register read-back
  function automatic logic [7:0] reg_read(input fsk_pkg::fsk_state_type s,
                                          input logic [6:0] a);
    case (a)
      `FSK_ADR_MODE_POWER: return s.regs.mode_power_control;
      `FSK_ADR_FRONT_END:  return s.regs.front_end_control;
      `FSK_ADR_SYNC_LOW:   return s.regs.sync_clock_select_low;
      `FSK_ADR_SYNC_HIGH:  return s.regs.sync_clock_select_high;
      `FSK_ADR_FILTER_CLK: return s.regs.channel_filter_clock;
      `FSK_ADR_BYPASS:     return s.regs.bypass_control;
      `FSK_ADR_STATUS:     return {6'h00, s.tx_overrun, ~s.fee_run};
      `FSK_ADR_FEE_CTRL:   return s.regs.freq_error_control;
      `FSK_ADR_FEE_RESULT: return s.fee_cnt;
      default:             return 8'h00;
    endcase
  endfunction

  // ------------
  // field decode
  // ------------
  assign mode     = fsk_pkg::fsk_mode_type'(
                    st_reg.regs.mode_power_control[`FSK_MODE_LSB +: 2]);
  assign rx       = (mode == fsk_pkg::FSK_RECEIVE);
  assign tx       = (mode == fsk_pkg::FSK_TRANSMIT);
  assign sync_en  = st_reg.regs.mode_power_control[`FSK_SYNC_EN_BIT];
  assign rsync_s  =
    st_reg.regs.sync_clock_select_low[`FSK_RSYNC_LSB +: 3];
  assign txrate_s = {st_reg.regs.sync_clock_select_low[`FSK_TXS_HI_BIT],
                     st_reg.regs.sync_clock_select_high[7:6]};
  assign ref_k    =
    st_reg.regs.sync_clock_select_high[`FSK_REFK_LSB +: 6];
  assign sc_div   = st_reg.regs.channel_filter_clock[`FSK_SCDIV_LSB +: 6];

  // ------------
  // shared reference divider and prescaled ticks
  // ------------
  // k of zero stops the sync and transmit bit clocks, not the filter clock
  assign ref_tick = (ref_k != 6'h00) && (st_reg.ref_cnt == ref_k - 6'h01);
  // sync tick at fxco/(k*2^(7-s)), meant as sixteen times bit rate
  assign bs_tick  = ref_tick &&
                    pre_hit(st_reg.pre_cnt, 3'h7 - rsync_s);
  // half-period tick so the toggled clock lands at fxco/(k*2^(7-s))
  assign tx_tick  = ref_tick && (txrate_s != 3'h7) &&
                    pre_hit(st_reg.pre_cnt, 3'h6 - txrate_s);

  // ------------
  // programming port edges and transmit sampling
  // ------------
  assign pg_rise   = prog_en_i && prog_clk_i && !st_reg.pg_clk_q;
  assign pg_fall   = prog_en_i && !prog_clk_i && st_reg.pg_clk_q;
  // transmit bit taken on the rising data clock edge
  assign tx_sample = tx && sync_en && tx_tick && !st_reg.tx_clk;
  assign fifo_push = tx_sample;
  assign up_q      = demod_up_i;
  assign dn_q      = demod_dn_i;

  // ------------
  // next-state logic
  // ------------
  always_comb begin
    logic [7:0] wd;
    logic [6:0] fee_len;
    logic       fee_restart;
    logic       bs_edge;
    wd          = {st_reg.pg_shift[6:0], prog_data_i};
    fee_restart = 1'b0;
    fee_len     = `FSK_FEE_BASE_SYMS <<
      st_reg.regs.freq_error_control[`FSK_FEE_LEN_LSB +: 2];
    bs_edge     = (demod_data_i != st_reg.bs_prev);
    st_next     = st_reg;
    st_next.pg_clk_q = prog_clk_i;
    st_next.rx_q     = rx;

    // three-wire frame: 7 address bits, read flag, 8 data bits
    case (st_reg.pg_state)
      fsk_pkg::FSK_PG_IDLE: begin
        st_next.pg_count = 4'h0;
        if (prog_en_i) begin
          st_next.pg_state = fsk_pkg::FSK_PG_HDR;
        end
      end
      fsk_pkg::FSK_PG_HDR: begin
        if (pg_rise) begin
          st_next.pg_shift = wd;
          st_next.pg_count = st_reg.pg_count + 4'h1;
          if (st_reg.pg_count == `FSK_PROG_HDR_BITS - 4'h1) begin
            st_next.pg_addr  = st_reg.pg_shift[6:0];
            st_next.pg_count = 4'h0;
            if (prog_data_i) begin
              st_next.pg_state = fsk_pkg::FSK_PG_RDATA;
              st_next.pg_shift = reg_read(st_reg, st_reg.pg_shift[6:0]);
              if (st_reg.pg_shift[6:0] == `FSK_ADR_STATUS) begin
                st_next.tx_overrun = 1'b0;
              end
            end else begin
              st_next.pg_state = fsk_pkg::FSK_PG_WDATA;
            end
          end
        end
      end
      fsk_pkg::FSK_PG_WDATA: begin
        if (pg_rise) begin
          st_next.pg_shift = wd;
          st_next.pg_count = st_reg.pg_count + 4'h1;
          if (st_reg.pg_count == `FSK_PROG_HDR_BITS - 4'h1) begin
            st_next.pg_state = fsk_pkg::FSK_PG_IDLE;
            case (st_reg.pg_addr)
              `FSK_ADR_MODE_POWER:
                st_next.regs.mode_power_control = wd | `FSK_SET_MODE_POWER;
              `FSK_ADR_FRONT_END:
                st_next.regs.front_end_control =
                  (wd & `FSK_KEEP_FRONT_END) | `FSK_SET_FRONT_END;
              `FSK_ADR_SYNC_LOW:
                st_next.regs.sync_clock_select_low = wd & `FSK_KEEP_SYNC_LOW;
              `FSK_ADR_SYNC_HIGH:
                st_next.regs.sync_clock_select_high = wd;
              `FSK_ADR_FILTER_CLK:
                st_next.regs.channel_filter_clock = wd | `FSK_SET_FILTER_CLK;
              `FSK_ADR_BYPASS:
                st_next.regs.bypass_control = wd & `FSK_KEEP_BYPASS;
              `FSK_ADR_FEE_CTRL: begin
                st_next.regs.freq_error_control = wd & `FSK_KEEP_FEE_CTRL;
                fee_restart = 1'b1;
              end
              default: ;
            endcase
          end
        end
      end
      fsk_pkg::FSK_PG_RDATA: begin
        if (pg_fall) begin
          st_next.pg_sdo   = st_reg.pg_shift[7];
          st_next.pg_shift = {st_reg.pg_shift[6:0], 1'b0};
        end
      end
      default: st_next.pg_state = fsk_pkg::FSK_PG_IDLE;
    endcase
    if (!prog_en_i) begin
      st_next.pg_state = fsk_pkg::FSK_PG_IDLE;
      st_next.pg_sdo   = 1'b0;
    end

    // shared reference divider feeds the sync and transmit bit clocks
    if (ref_k == 6'h00 || ref_tick) begin
      st_next.ref_cnt = 6'h00;
    end else begin
      st_next.ref_cnt = st_reg.ref_cnt + 6'h01;
    end
    if (ref_tick) begin
      st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
    end

    // filter clock: toggle every div cycles, period 2*div
    if (sc_div == 6'h00 || st_reg.sc_cnt >= sc_div - 6'h01) begin
      st_next.sc_cnt = 6'h00;
      st_next.sc_clk = (sc_div != 6'h00) && !st_reg.sc_clk;
    end else begin
      st_next.sc_cnt = st_reg.sc_cnt + 6'h01;
    end

    // bit synchronizer: sixteen phases, one step per data edge
    if (bs_tick) begin
      st_next.bs_prev  = demod_data_i;
      st_next.bs_phase = st_reg.bs_phase + 4'h1;
      if (bs_edge && st_reg.bs_phase > `FSK_PHASE_ZERO &&
          st_reg.bs_phase < `FSK_PHASE_CENTER) begin
        st_next.bs_phase = st_reg.bs_phase;
      end else if (bs_edge && st_reg.bs_phase > `FSK_PHASE_CENTER) begin
        st_next.bs_phase = st_reg.bs_phase + 4'h2;
      end
      if (st_reg.bs_phase == `FSK_PHASE_CENTER) begin
        st_next.bs_bit = demod_data_i;
      end
    end

    // data clock pin and data pin drive
    st_next.dclk = 1'b0;
    st_next.dout = 1'b0;
    if (rx) begin
      if (sync_en) begin
        // clock rises with each new bit, one clock per bit
        st_next.dclk = (st_next.bs_phase > `FSK_PHASE_CENTER);
        st_next.dout = st_next.bs_bit;
      end else begin
        st_next.dout = demod_data_i;
      end
    end else if (tx && sync_en) begin
      st_next.dclk = tx_tick ? !st_reg.tx_clk : st_reg.tx_clk;
    end

    // transmit bit clock and overrun when fifo is full
    if (!(tx && sync_en)) begin
      st_next.tx_clk = 1'b0;
    end else if (tx_tick) begin
      st_next.tx_clk = !st_reg.tx_clk;
    end
    if (fifo_push && !fifo_in_ready) begin
      st_next.tx_overrun = 1'b1;
    end

    // tone selection per transmitted bit
    if (tx && !sync_en) begin
      st_next.tone = serial_data_pin_i;
    end else if (tx && fifo_out_valid && tone_ready_i) begin
      st_next.tone = fifo_out_data[0];
    end

    // frequency error estimator
    if (rx && !st_reg.rx_q) begin
      fee_restart = 1'b1;
    end
    if (fee_restart) begin
      st_next.fee_cnt = 8'h00;
      st_next.fee_sym = 7'h00;
      st_next.fee_run = 1'b1;
    end else if (st_reg.fee_run && rx) begin
      case (st_reg.regs.freq_error_control[1:0])
        2'b01: st_next.fee_cnt = st_reg.fee_cnt + {7'h00, up_q};
        2'b10: st_next.fee_cnt = st_reg.fee_cnt - {7'h00, dn_q};
        2'b11: st_next.fee_cnt = st_reg.fee_cnt + {7'h00, up_q}
                                 - {7'h00, dn_q};
        default: st_next.fee_cnt = st_reg.fee_cnt;
      endcase
      if (st_reg.regs.freq_error_control[1:0] == 2'b00) begin
        st_next.fee_run = 1'b0;
      end else if (bs_tick && st_reg.bs_phase == `FSK_PHASE_CENTER) begin
        st_next.fee_sym = st_reg.fee_sym + 7'h01;
        if (st_reg.fee_sym + 7'h01 == fee_len) begin
          st_next.fee_run = 1'b0;
        end
      end
    end
  end

  // ------------
  // state register
  // ------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.regs.mode_power_control     <= `FSK_RST_MODE_POWER;
      st_reg.regs.front_end_control      <= `FSK_RST_FRONT_END;
      st_reg.regs.sync_clock_select_low  <= `FSK_RST_SYNC_LOW;
      st_reg.regs.sync_clock_select_high <= `FSK_RST_SYNC_HIGH;
      st_reg.regs.channel_filter_clock   <= `FSK_RST_FILTER_CLK;
      st_reg.regs.bypass_control         <= `FSK_RST_ZERO;
      st_reg.regs.freq_error_control     <= `FSK_RST_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------
  // transmit bit buffer
  // ------------
  fsk_fifo #(
    .WIDTH (1),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (serial_data_pin_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tone_ready_i && tx && sync_en),
    .out_data_o  (fifo_out_data)
  );

  // ------------
  // outputs
  // ------------
  assign prog_data_o            = st_reg.pg_sdo;
  assign prog_data_oe_n_o       = (st_reg.pg_state != fsk_pkg::FSK_PG_RDATA);
  assign bit_clock_pin_o        = st_reg.dclk;
  assign serial_data_pin_o      = st_reg.dout;
  assign serial_data_pin_oe_n_o = !st_reg.rx_q;
  // filter clock held low while bypassed
  assign filter_clock_o          = st_reg.sc_clk &&
    !st_reg.regs.bypass_control[`FSK_SCBYP_BIT];
  assign channel_filter_bypass_o =
    st_reg.regs.bypass_control[`FSK_SCBYP_BIT];
  assign output_power_level_o   =
    st_reg.regs.mode_power_control[`FSK_PA_LSB +: 3];
  assign amplifier_enable_o     =
    |st_reg.regs.mode_power_control[`FSK_PA_LSB +: 3];
  assign amplifier_bypass_o     =
    st_reg.regs.bypass_control[`FSK_PABYP_BIT];
  assign one_tone_dividers_o    = st_reg.tone;
  assign mode_o                 = mode;
endmodule // fsk_baseband_ctrl

//--- rtl/fsk_defines.svh
// register offsets, fixed bits, reset values and field positions
`ifndef FSK_DEFINES_SVH
`define FSK_DEFINES_SVH
// ------------
// register offsets (7-bit addresses)
// ------------
`define FSK_ADR_MODE_POWER   7'h00
`define FSK_ADR_FRONT_END    7'h01
`define FSK_ADR_SYNC_LOW     7'h06
`define FSK_ADR_SYNC_HIGH    7'h07
`define FSK_ADR_FILTER_CLK   7'h08
`define FSK_ADR_BYPASS       7'h09
`define FSK_ADR_STATUS       7'h0A
`define FSK_ADR_FEE_CTRL     7'h15
`define FSK_ADR_FEE_RESULT   7'h16
// ------------
// reset values and fixed bits
// ------------
`define FSK_RST_MODE_POWER   8'h01
`define FSK_RST_FRONT_END    8'h80
`define FSK_RST_SYNC_LOW     8'h00
`define FSK_RST_SYNC_HIGH    8'h01
`define FSK_RST_FILTER_CLK   8'hC1
`define FSK_RST_ZERO         8'h00
`define FSK_SET_MODE_POWER   8'h01
`define FSK_SET_FRONT_END    8'h80
`define FSK_KEEP_FRONT_END   8'h0F
`define FSK_KEEP_SYNC_LOW    8'h0F
`define FSK_SET_FILTER_CLK   8'hC0
`define FSK_KEEP_FEE_CTRL    8'h0F
`define FSK_KEEP_BYPASS      8'h03
// ------------
// field positions
// ------------
`define FSK_MODE_LSB         1
`define FSK_SYNC_EN_BIT      3
`define FSK_PA_LSB           4
`define FSK_RSYNC_LSB        1
`define FSK_TXS_HI_BIT       0
`define FSK_REFK_LSB         0
`define FSK_SCDIV_LSB        0
`define FSK_FEE_LEN_LSB      2
`define FSK_SCBYP_BIT        0
`define FSK_PABYP_BIT        1
// ------------
// bit synchronizer phases and frame sizes
// ------------
`define FSK_PHASE_CENTER     4'h8
`define FSK_PHASE_ZERO       4'h0
`define FSK_FEE_BASE_SYMS    7'h08
`define FSK_PROG_HDR_BITS    4'h8
`endif

//--- rtl/fsk_pkg.sv
// shared types of the transceiver control block
package fsk_pkg;
  // operating modes of the transceiver
  typedef enum logic [1:0] {
    FSK_POWER_DOWN = 2'b00,
    FSK_STANDBY    = 2'b01,
    FSK_RECEIVE    = 2'b10,
    FSK_TRANSMIT   = 2'b11
  } fsk_mode_type;
  // phases of the three-wire programming frame
  typedef enum logic [1:0] {
    FSK_PG_IDLE  = 2'b00,
    FSK_PG_HDR   = 2'b01,
    FSK_PG_WDATA = 2'b10,
    FSK_PG_RDATA = 2'b11
  } fsk_pg_type;
  // register bank
  typedef struct packed {
    logic [7:0] mode_power_control;
    logic [7:0] front_end_control;
    logic [7:0] sync_clock_select_low;
    logic [7:0] sync_clock_select_high;
    logic [7:0] channel_filter_clock;
    logic [7:0] bypass_control;
    logic [7:0] freq_error_control;
  } fsk_regs_type;
  // whole state of the control block
  typedef struct packed {
    fsk_regs_type regs;
    fsk_pg_type   pg_state;
    logic [7:0]   pg_shift;
    logic [6:0]   pg_addr;
    logic [3:0]   pg_count;
    logic         pg_clk_q;
    logic         pg_sdo;
    logic [5:0]   ref_cnt;
    logic [6:0]   pre_cnt;
    logic [5:0]   sc_cnt;
    logic         sc_clk;
    logic [3:0]   bs_phase;
    logic         bs_prev;
    logic         bs_bit;
    logic         tx_clk;
    logic         tx_overrun;
    logic         dclk;
    logic         dout;
    logic         tone;
    logic [7:0]   fee_cnt;
    logic [6:0]   fee_sym;
    logic         fee_run;
    logic         rx_q;
  } fsk_state_type;
endpackage : fsk_pkg

//--- rtl/fsk_fifo.sv
// small valid/ready fifo for transmit bits
`timescale 1ns/1ps
module fsk_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 level;
  } fsk_fifo_state_type;
  fsk_fifo_state_type st_reg;
  fsk_fifo_state_type st_next;
  logic push;
  logic pop;
  // honest full and empty from the fill level
  assign in_ready_o  = (st_reg.level != (AW+1)'(DEPTH));
  assign out_valid_o = (st_reg.level != '0);
  assign out_data_o  = st_reg.mem[st_reg.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  // pointer and level update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data_i;
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
    end
    st_next.level = st_reg.level + (AW+1)'(push) - (AW+1)'(pop);
  end
  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // fsk_fifo

//--- testbench/fsk_ctrl_chk.sv
// port assertions of the fsk control block
`timescale 1ns/1ps
module fsk_ctrl_chk (
  // watched ports
  input logic       clk_i,
  input logic       rst_n_i,
  input logic       prog_en_i,
  input logic       prog_data_oe_n_o,
  input logic       bit_clock_pin_o,
  input logic       serial_data_pin_o,
  input logic       serial_data_pin_oe_n_o,
  input logic       filter_clock_o,
  input logic       channel_filter_bypass_o,
  input logic [2:0] output_power_level_o,
  input logic       amplifier_enable_o,
  input logic [1:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [6:0] run_q;
  // cycles since the filter clock last moved
  always_ff @(posedge clk_i)
    run_q <= ($changed(filter_clock_o) || channel_filter_bypass_o
              || !rst_n_i) ? 7'h00 : run_q + 7'h01;
  chk_amp_on: assert property (
    amplifier_enable_o == (|output_power_level_o)) else $error("amp on");
  chk_pin_rx: assert property (
    mode_o == 2'b10 && $past(mode_o) == 2'b10 |-> !serial_data_pin_oe_n_o)
    else $error("pin not driven in rx");
  chk_pin_tx: assert property (
    mode_o == 2'b11 && $past(mode_o) == 2'b11 |-> serial_data_pin_oe_n_o)
    else $error("pin driven in tx");
  chk_byp_quiet: assert property (
    channel_filter_bypass_o && $past(channel_filter_bypass_o)
    |-> !filter_clock_o) else $error("filter clock while bypassed");
  chk_filter_half: assert property (run_q <= 7'h3F)
    else $error("filter clock half period too long");
  chk_rx_launch: assert property (
    mode_o == 2'b10 && $past(mode_o) == 2'b10 && bit_clock_pin_o
    && $changed(serial_data_pin_o) |-> $rose(bit_clock_pin_o))
    else $error("rx data moved off rising clock");
  chk_idle_clock: assert property (
    !mode_o[1] && $past(!mode_o[1]) |-> !bit_clock_pin_o)
    else $error("bit clock outside rx and tx");
  chk_reset_state: assert property ($rose(rst_n_i) |->
    serial_data_pin_oe_n_o && prog_data_oe_n_o && !bit_clock_pin_o
    && mode_o == 2'b00) else $error("state after reset");
  chk_readback_off: assert property (
    !prog_en_i && $past(!prog_en_i) |-> prog_data_oe_n_o)
    else $error("read-back driven outside frame");
  // main scenarios
  cover property ($rose(bit_clock_pin_o) && mode_o == 2'b10);
  cover property ($rose(bit_clock_pin_o) && mode_o == 2'b11);
  cover property (!prog_data_oe_n_o);
endmodule // fsk_ctrl_chk
bind fsk_baseband_ctrl fsk_ctrl_chk fsk_ctrl_chk_i (.clk_i, .rst_n_i,
  .prog_en_i, .prog_data_oe_n_o, .bit_clock_pin_o, .serial_data_pin_o,
  .serial_data_pin_oe_n_o, .filter_clock_o, .channel_filter_bypass_o,
  .output_power_level_o, .amplifier_enable_o, .mode_o);

//--- testbench/fsk_host_model.sv
// host model driving and sampling the serial data pin
`timescale 1ns/1ps
module fsk_host_model (
  // device pins
  input  logic       clk_i,
  input  logic       bit_clock_pin_i,
  input  logic       dev_data_i,
  input  logic       dev_oe_n_i,
  input  logic [1:0] mode_i,
  // bench side
  input  logic [7:0] tx_word_i,
  output logic       pin_level_o,
  output logic       tx_bit_o,
  output logic [7:0] rx_shift_o
);
  logic [2:0] idx = 3'h0;
  logic       junk = 1'b0;
  // undriven wire level changes every cycle
  always @(posedge clk_i) junk <= ~junk;
  // host samples and changes data on the falling bit clock edge
  always @(negedge bit_clock_pin_i) begin
    rx_shift_o <= {rx_shift_o[6:0], pin_level_o};
    idx        <= idx + 3'h1;
  end
  // host drives the pin only while transmitting
  assign tx_bit_o    = tx_word_i[idx];
  assign pin_level_o = !dev_oe_n_i ? dev_data_i
                     : (mode_i == 2'b11) ? tx_bit_o : junk;
endmodule // fsk_host_model

//--- testbench/tb.sv
// self-checking bench of the fsk control block
`timescale 1ns/1ps
module tb;
  // design inputs
  logic clk_i = 1'b0, rst_n_i = 1'b0, prog_en_i = 1'b0, prog_clk_i = 1'b0;
  logic prog_data_i = 1'b0, demod_data_i = 1'b0, tone_ready_i = 1'b1;
  logic demod_up_i = 1'b0, demod_dn_i = 1'b0;
  // design outputs and the shared data wire
  logic prog_data_o, prog_data_oe_n_o, bit_clock_pin_o, filter_clock_o;
  logic serial_data_pin_i, serial_data_pin_o, serial_data_pin_oe_n_o;
  logic channel_filter_bypass_o, amplifier_enable_o, amplifier_bypass_o;
  logic one_tone_dividers_o, tx_bit;
  logic [2:0]  output_power_level_o;
  logic [1:0]  mode_o;
  logic [7:0]  r, v, e, hr, tx_word = 8'h00;
  logic [31:0] seed = 32'h00000FB3;
  int          n_mismatch = 0, compares = 0;
  logic [6:0]  adr [6] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h15};
  logic [7:0]  rstv [6] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'hC1, 8'h00};
  fsk_baseband_ctrl fsk_baseband_ctrl_i (.*);
  fsk_host_model fsk_host_model_i (.clk_i, .bit_clock_pin_i(bit_clock_pin_o),
    .dev_data_i(serial_data_pin_o), .dev_oe_n_i(serial_data_pin_oe_n_o),
    .mode_i(mode_o), .tx_word_i(tx_word), .pin_level_o(serial_data_pin_i),
    .tx_bit_o(tx_bit), .rx_shift_o(hr));
  // clock and a demodulator stream toggling every sixteen cycles
  always #50 clk_i = ~clk_i;
  always begin
    repeat (16) @(negedge clk_i);
    demod_data_i = ~demod_data_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // read-back value after fixed bits are forced
  function automatic logic [7:0] fixed(input logic [6:0] a, logic [7:0] d);
    case (a)
      7'h00: return d | 8'h01;
      7'h01: return (d & 8'h0F) | 8'h80;
      7'h06, 7'h15: return d & 8'h0F;
      7'h08: return d | 8'hC0;
      default: return d;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one programming frame: address, read flag, data, msb first
  task automatic xfer(input logic [15:0] f, output logic [7:0] q);
    prog_en_i = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      prog_clk_i = 1'b0;
      prog_data_i = f[i];
      repeat (2) @(negedge clk_i);
      if (i < 8) q[i] = prog_data_o;
      prog_clk_i = 1'b1;
      repeat (2) @(negedge clk_i);
    end
    prog_en_i = 1'b0;
    prog_clk_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer({a, 1'b0, d}, q);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    xfer({a, 1'b1, 8'h00}, q);
  endtask
  // up/down pulse every other cycle
  task automatic burst(input int n, input logic [1:0] ud);
    for (int k = 0; k < n; k++) begin
      {demod_dn_i, demod_up_i} = k[0] ? 2'b00 : ud;
      @(negedge clk_i);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (adr[i]) begin
      rd(adr[i], r);
      chk("reset", r, rstv[i]);
      v = 8'(rnd()) | 8'(adr[i] == 7'h08); // keep filter clock running
      wr(adr[i], v);
      rd(adr[i], r);
      chk("field", r, fixed(adr[i], v));
      wr(adr[i], rstv[i]);
    end
    wr(7'h16, 8'hFF);
    rd(7'h16, r);
    chk("result_ro", r, 8'h00);
    rd(7'h30, r);
    chk("unmapped", r, 8'h00);
    for (int p = 0; p < 8; p++) begin
      wr(7'h00, {1'b0, p[2:0], 4'h3});
      wr(7'h09, {6'h00, p[1:0]});
      chk("pa", {amplifier_bypass_o, channel_filter_bypass_o,
        amplifier_enable_o, 2'b00, output_power_level_o},
        {p[1:0], p != 0, 2'b00, p[2:0]});
    end
    wr(7'h09, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h3F : 8'(rnd() % 63 + 1);
      wr(7'h08, v);
      repeat (2) @(posedge filter_clock_o);
      @(negedge clk_i);
      e = 8'h00;
      while (filter_clock_o === 1'b1 && e < 8'h50) begin
        e = e + 8'h01;
        @(negedge clk_i);
      end
      chk("sc_half", e, v);
    end
    wr(7'h06, 8'h0E);
    wr(7'h00, 8'h0D);
    for (int m = 0; m < 4; m++) begin
      wr(7'h15, 8'(m));
      e = 8'h00;
      repeat (50) begin
        v = 8'(rnd());
        burst(2, v[1:0]);
        e = e + 8'(v[0] & m[0]) - 8'(v[1] & m[1]);
      end
      rd(7'h16, r);
      chk("fee_mode", r, e);
    end
    wr(7'h15, 8'h0E);
    burst(260, 2'b10);
    rd(7'h16, r);
    chk("fee_wrap", r, 8'h7E);
    wr(7'h15, 8'h01);
    burst(300, 2'b01);
    rd(7'h16, r);
    chk("fee_stop", {7'h00, r > 8'h32 && r < 8'h44}, 8'h01);
    chk("rx_bits", {7'h00, hr[3:0] == 4'h5 || hr[3:0] == 4'hA},
      8'h01);
    tx_word = 8'(rnd());
    wr(7'h06, 8'h0F);
    wr(7'h00, 8'h0F);
    repeat (8) begin
      @(posedge bit_clock_pin_o);
      repeat (4) @(negedge clk_i);
      chk("tone", {7'h00, one_tone_dividers_o}, {7'h00, tx_bit});
    end
    tone_ready_i = 1'b0;
    repeat (12) @(posedge bit_clock_pin_o);
    @(negedge clk_i);
    tone_ready_i = 1'b1;
    repeat (20) @(negedge clk_i);
    rd(7'h0A, r);
    chk("overrun", r & 8'h02, 8'h02);
    rd(7'h0A, r);
    chk("ovr_clear", r & 8'h02, 8'h00);
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
